// *** spio_port.sv ***
// Sixteen-pin I/O port with low-power sequencing and byte store access.
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module spio_port #(
   parameter int unsigned WAKE_CYCLES   = spio_pkg::WAKE_CYCLES,
   parameter int unsigned GLITCH_CYCLES = spio_pkg::GLITCH_CYCLES,
   parameter int          PINS          = spio_pkg::PIN_COUNT
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // AHB-Lite slave
   input  wire logic             hsel_in,
   input  wire logic [31:0]      haddr_in,
   input  wire logic [1:0]       htrans_in,
   input  wire logic             hwrite_in,
   input  wire logic [2:0]       hsize_in,
   input  wire logic [31:0]      hwdata_in,
   input  wire logic             hready_in,
   output logic                  hreadyout_out,
   output logic                  hresp_out,
   output logic      [31:0]      hrdata_out,
   // Pins
   input  wire logic [PINS-1:0]  pin_in,
   output logic      [PINS-1:0]  pin_out,
   output logic      [PINS-1:0]  pin_oe_out,
   // Core supervision
   output logic                  core_reset_out
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic                         addr_ok;
   logic                         wr_pend_q;
   logic                         rd_nv;
   logic [7:0]                   addr_q;
   logic                         wr_act;
   logic [1:0]                   nv_wait_q;
   logic [PINS-1:0]              pin_direction_word_q;
   logic [PINS-1:0]              pin_drive_latch_q;
   logic [PINS-1:0]              sync_meta_q;
   logic [PINS-1:0]              pin_sampled_levels_q;
   logic [PINS-1:0]              pin_oe_q;
   logic [31:0]                  rd_word;
   spio_pkg::spio_state_t        state_q;
   logic [7:0]                   sleep_left_q;
   logic [31:0]                  glitch_cnt_q;
   logic                         glitch_act;
   logic                         wdog_expire;
   logic                         wdog_restart;
   logic [spio_pkg::NV_ADDR_W-1:0] nv_addr_q;
   logic [7:0]                   nv_rdata;
   logic                         nv_we;
   logic [3:0]                   cmd_pin;
   logic [7:0]                   ctl_count;

   // Register hit for an active write data phase.
   function automatic logic reg_hit(input logic       act,
                                    input logic [7:0] addr,
                                    input logic [7:0] off);
      return act && (addr == off);
   endfunction : reg_hit

   // ------------------------------------------------------------------
   // Bus address phase
   // ------------------------------------------------------------------
   assign addr_ok = hsel_in && htrans_in[1] && hready_in;
   assign rd_nv   = addr_ok && !hwrite_in &&
                    (haddr_in[7:0] == spio_pkg::OFF_NV_DATA);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end else begin
         wr_pend_q <= addr_ok && hwrite_in;
         if (addr_ok) begin
            addr_q <= haddr_in[7:0];
         end
      end
   end

   // Software is the sleeping or stopped core: writes only count while
   // the program runs.
   assign wr_act = wr_pend_q && (state_q == spio_pkg::ST_RUN);

   // A store read needs the fresh address to pass through the memory's
   // read register, hence two wait states.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         nv_wait_q <= 2'h0;
      end else if (rd_nv) begin
         nv_wait_q <= spio_pkg::NV_WAIT_START;
      end else if (nv_wait_q != 2'h0) begin
         nv_wait_q <= nv_wait_q - 2'h1;
      end
   end

   assign hreadyout_out = (nv_wait_q == 2'h0);
   assign hresp_out     = 1'b0;

   // ------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------
   always_comb begin
      rd_word = 32'h0000_0000;
      case (haddr_in[7:0])
         spio_pkg::OFF_DIR:      rd_word[PINS-1:0] = pin_direction_word_q;
         spio_pkg::OFF_DRIVE:    rd_word[PINS-1:0] = pin_drive_latch_q;
         spio_pkg::OFF_SAMPLED:  rd_word[PINS-1:0] = pin_sampled_levels_q;
         spio_pkg::OFF_SAMP_LO:  rd_word[7:0] = pin_sampled_levels_q[7:0];
         spio_pkg::OFF_SAMP_HI:  rd_word[7:0] = pin_sampled_levels_q[15:8];
         spio_pkg::OFF_DRIVE_LO: rd_word[7:0] = pin_drive_latch_q[7:0];
         spio_pkg::OFF_DRIVE_HI: rd_word[7:0] = pin_drive_latch_q[15:8];
         spio_pkg::OFF_CONTROL: begin
            rd_word[3:0]                    = state_q;
            rd_word[spio_pkg::STS_GLITCH_BIT] = glitch_act;
            rd_word[15:8]                   = sleep_left_q;
         end
         spio_pkg::OFF_NV_ADDR:
            rd_word[spio_pkg::NV_ADDR_W-1:0] = nv_addr_q;
         default:                rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         hrdata_out <= 32'h0000_0000;
      end else if (nv_wait_q == 2'h1) begin
         hrdata_out <= {24'h000000, nv_rdata};
      end else if (addr_ok && !hwrite_in) begin
         hrdata_out <= rd_word;
      end
   end

   // ------------------------------------------------------------------
   // Direction word and drive latch
   // ------------------------------------------------------------------
   assign cmd_pin = hwdata_in[spio_pkg::CMD_PIN_LSB +: 4];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pin_direction_word_q <= spio_pkg::DIR_RESET;
      end else if (reg_hit(wr_act, addr_q, spio_pkg::OFF_DIR)) begin
         pin_direction_word_q <= hwdata_in[PINS-1:0];
      end else if (reg_hit(wr_act, addr_q, spio_pkg::OFF_PIN_CMD)) begin
         pin_direction_word_q[cmd_pin] <= 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pin_drive_latch_q <= spio_pkg::DRIVE_RESET;
      end else begin
         // Stored regardless of direction; only the enable gates the pin.
         if (reg_hit(wr_act, addr_q, spio_pkg::OFF_DRIVE)) begin
            pin_drive_latch_q <= hwdata_in[PINS-1:0];
         end
         if (reg_hit(wr_act, addr_q, spio_pkg::OFF_DRIVE_LO)) begin
            pin_drive_latch_q[7:0] <= hwdata_in[7:0];
         end
         if (reg_hit(wr_act, addr_q, spio_pkg::OFF_DRIVE_HI)) begin
            pin_drive_latch_q[15:8] <= hwdata_in[7:0];
         end
         if (reg_hit(wr_act, addr_q, spio_pkg::OFF_PIN_CMD)) begin
            pin_drive_latch_q[cmd_pin] <=
               hwdata_in[spio_pkg::CMD_LEVEL_BIT];
         end
      end
   end

   // ------------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pin_out  <= spio_pkg::DRIVE_RESET;
         pin_oe_q <= spio_pkg::DIR_RESET;
      end else begin
         pin_out  <= pin_drive_latch_q;
         // Directions are held aside, so they come back after the glitch.
         pin_oe_q <= pin_direction_word_q & {PINS{!glitch_act}};
      end
   end

   assign pin_oe_out = pin_oe_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sync_meta_q          <= '0;
         pin_sampled_levels_q <= '0;
      end else begin
         sync_meta_q          <= pin_in;
         pin_sampled_levels_q <= sync_meta_q;
      end
   end

   // ------------------------------------------------------------------
   // Operating state
   // ------------------------------------------------------------------
   assign ctl_count = hwdata_in[spio_pkg::CTL_COUNT_LSB +: 8];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_q      <= spio_pkg::ST_RUN;
         sleep_left_q <= 8'h00;
      end else begin
         case (state_q)
            spio_pkg::ST_RUN: begin
               if (reg_hit(wr_act, addr_q, spio_pkg::OFF_CONTROL)) begin
                  if (hwdata_in[spio_pkg::CTL_HALT_BIT]) begin
                     state_q <= spio_pkg::ST_HALT;
                  end else if (hwdata_in[spio_pkg::CTL_END_BIT]) begin
                     state_q <= spio_pkg::ST_ENDED;
                  end else if (hwdata_in[spio_pkg::CTL_SLEEP_BIT]) begin
                     state_q      <= spio_pkg::ST_SLEEP;
                     sleep_left_q <= (ctl_count == 8'h00) ? 8'h01
                                                          : ctl_count;
                  end else if (hwdata_in[spio_pkg::CTL_NAP_BIT]) begin
                     state_q      <= spio_pkg::ST_SLEEP;
                     sleep_left_q <= 8'h01;
                  end
               end
            end
            spio_pkg::ST_SLEEP: begin
               if (wdog_expire) begin
                  if (sleep_left_q == 8'h01) begin
                     state_q <= spio_pkg::ST_RUN;
                  end
                  sleep_left_q <= sleep_left_q - 8'h01;
               end
            end
            spio_pkg::ST_ENDED: state_q <= spio_pkg::ST_ENDED;
            spio_pkg::ST_HALT:  state_q <= spio_pkg::ST_HALT;
            default:            state_q <= spio_pkg::ST_RUN;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Watchdog, wake glitch and core reset
   // ------------------------------------------------------------------
   // Restarting on every control write aligns the first wake a full period
   // after entering low power.
   assign wdog_restart = reg_hit(wr_act, addr_q, spio_pkg::OFF_KICK) ||
                         reg_hit(wr_act, addr_q, spio_pkg::OFF_CONTROL);

   spio_wdog #(
      .PERIOD     (WAKE_CYCLES)
   ) u_wdog (
      .clk_in     (clk_in),
      .rst_in     (rst_in),
      .run_in     (state_q != spio_pkg::ST_HALT),
      .restart_in (wdog_restart),
      .expire_out (wdog_expire)
   );

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         glitch_cnt_q <= 32'h0000_0000;
      end else if (wdog_expire) begin
         glitch_cnt_q <= 32'(GLITCH_CYCLES);
      end else if (glitch_cnt_q != 32'h0000_0000) begin
         glitch_cnt_q <= glitch_cnt_q - 32'h0000_0001;
      end
   end

   assign glitch_act = (glitch_cnt_q != 32'h0000_0000);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         core_reset_out <= 1'b0;
      end else begin
         core_reset_out <= wdog_expire &&
                           (state_q == spio_pkg::ST_RUN);
      end
   end

   // ------------------------------------------------------------------
   // Byte store
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         nv_addr_q <= '0;
      end else if (reg_hit(wr_act, addr_q, spio_pkg::OFF_NV_ADDR)) begin
         nv_addr_q <= hwdata_in[spio_pkg::NV_ADDR_W-1:0];
      end
   end

   // Only the low byte of a write lands; a word takes two addresses.
   assign nv_we = reg_hit(wr_act, addr_q, spio_pkg::OFF_NV_DATA);

   spio_nvm #(
      .ADDR_W    (spio_pkg::NV_ADDR_W),
      .DEPTH     (spio_pkg::NV_DEPTH)
   ) u_nvm (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .addr_in   (nv_addr_q),
      .we_in     (nv_we),
      .wdata_in  (hwdata_in[7:0]),
      .rdata_out (nv_rdata)
   );

endmodule : spio_port

// *** spio_pkg.sv ***
// Shared constants for the sixteen-pin general-purpose I/O port.
package spio_pkg;

   // ------------------------------------------------------------------
   // Port geometry
   // ------------------------------------------------------------------
   localparam int                PIN_COUNT      = 16;
   localparam int                NV_ADDR_W      = 11;
   localparam int                NV_DEPTH       = 2048;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam longint            CLK_FREQ_HZ    = 250_000_000;
   localparam longint            WAKE_PERIOD_MS = 2300;
   localparam longint            GLITCH_TIME_US = 18000;
   localparam logic [31:0]       WAKE_CYCLES    =
      32'(WAKE_PERIOD_MS * CLK_FREQ_HZ / 1000);
   localparam logic [31:0]       GLITCH_CYCLES  =
      32'(GLITCH_TIME_US * CLK_FREQ_HZ / 1_000_000);

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0]        OFF_DIR        = 8'h00;
   localparam logic [7:0]        OFF_DRIVE      = 8'h04;
   localparam logic [7:0]        OFF_SAMPLED    = 8'h08;
   localparam logic [7:0]        OFF_SAMP_LO    = 8'h0c;
   localparam logic [7:0]        OFF_SAMP_HI    = 8'h10;
   localparam logic [7:0]        OFF_DRIVE_LO   = 8'h14;
   localparam logic [7:0]        OFF_DRIVE_HI   = 8'h18;
   localparam logic [7:0]        OFF_PIN_CMD    = 8'h1c;
   localparam logic [7:0]        OFF_CONTROL    = 8'h20;
   localparam logic [7:0]        OFF_KICK       = 8'h24;
   localparam logic [7:0]        OFF_NV_ADDR    = 8'h28;
   localparam logic [7:0]        OFF_NV_DATA    = 8'h2c;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int                CMD_PIN_LSB    = 0;
   localparam int                CMD_LEVEL_BIT  = 4;
   localparam int                CTL_SLEEP_BIT  = 0;
   localparam int                CTL_NAP_BIT    = 1;
   localparam int                CTL_END_BIT    = 2;
   localparam int                CTL_HALT_BIT   = 3;
   localparam int                CTL_COUNT_LSB  = 8;
   localparam int                STS_GLITCH_BIT = 4;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [15:0]       DIR_RESET      = 16'h0000;
   localparam logic [15:0]       DRIVE_RESET    = 16'h0000;
   localparam logic [1:0]        NV_WAIT_START  = 2'h2;

   // ------------------------------------------------------------------
   // Operating states
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RUN   = 4'b0001,
      ST_SLEEP = 4'b0010,
      ST_ENDED = 4'b0100,
      ST_HALT  = 4'b1000
   } spio_state_t;

endpackage : spio_pkg

// *** spio_wdog.sv ***
// Watchdog period counter, held at zero while run_in is low, with restart and expiry pulse.
`timescale 1ns/1ps
module spio_wdog #(
   parameter int unsigned PERIOD = 32'd575000000
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // Control
   input  wire logic run_in,
   input  wire logic restart_in,
   // Event
   output logic      expire_out
);

   logic [31:0] count_q;

   always_ff @(posedge clk_in) begin
      if (rst_in || restart_in || !run_in) begin
         count_q <= 32'h0000_0000;
      end else if (count_q == 32'(PERIOD - 1)) begin
         count_q <= 32'h0000_0000;
      end else begin
         count_q <= count_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         expire_out <= 1'b0;
      end else begin
         expire_out <= run_in && !restart_in &&
                       (count_q == 32'(PERIOD - 1));
      end
   end

endmodule : spio_wdog

// *** spio_nvm.sv ***
// Byte-organised nonvolatile store with registered read data.
`timescale 1ns/1ps
module spio_nvm #(
   parameter int ADDR_W = 11,
   parameter int DEPTH  = 2048
) (
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   // Access
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic              we_in,
   input  wire logic [7:0]        wdata_in,
   output logic      [7:0]        rdata_out
);

   logic [7:0] mem_q [DEPTH];

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem_q[addr_in] <= wdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
      end else begin
         rdata_out <= mem_q[addr_in];
      end
   end

endmodule : spio_nvm

// *** spio_port_monitor.sv ***
// Bus and pin timing checker for the sixteen-pin port.
`timescale 1ns/1ps
module spio_port_monitor #(
   parameter int unsigned WAKE_CYCLES = spio_pkg::WAKE_CYCLES
) (
   // Clock and reset
   input wire logic        clk_in,
   input wire logic        rst_in,
   // Bus
   input wire logic        hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0]  htrans_in,
   input wire logic        hwrite_in,
   input wire logic        hready_in,
   input wire logic        hreadyout_out,
   input wire logic [31:0] hrdata_out,
   // Pins
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe_out,
   input wire logic        core_reset_out
);
   logic        take;
   logic        rtake;
   logic        rd2c;
   logic        kick;
   logic [31:0] idle_q;
   assign take  = hsel_in & htrans_in[1] & hready_in;
   assign rtake = take & !hwrite_in;
   assign rd2c  = rtake & (haddr_in[7:0] == 8'h2c);
   assign kick  = take & hwrite_in & (haddr_in[7:0] inside {8'h20, 8'h24});
   // Time since software last restarted the watchdog or the core was last reset.
   always_ff @(posedge clk_in) begin
      if (rst_in || kick || core_reset_out)
         idle_q <= 32'h0;
      else
         idle_q <= idle_q + 32'h1;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   reset_inputs_a: assert property ($past(rst_in) |->
      pin_oe_out == 16'h0 && pin_out == 16'h0) else $error("pins after reset");
   drive_hold_a: assert property (!$past(take & hwrite_in, 3)
      && !$past(rst_in) |-> $stable(pin_out)) else $error("pin drive moved");
   data_stands_a: assert property ($changed(hrdata_out) |->
      $past(rtake) || !$past(hreadyout_out) || $past(rst_in))
      else $error("read data moved");
   fast_ready_a: assert property (take && !rd2c |=> hreadyout_out)
      else $error("register wait state");
   store_wait_a: assert property (rd2c |=>
      !hreadyout_out [*2] ##1 hreadyout_out) else $error("store wait");
   pulse_one_a: assert property (core_reset_out |=> !core_reset_out)
      else $error("core reset too long");
   wdog_idle_a: assert property (core_reset_out |->
      idle_q >= WAKE_CYCLES / 2) else $error("core reset too early");
   glitch_input_a: assert property ($rose(core_reset_out) |->
      ##[0:2] pin_oe_out == 16'h0) else $error("no input glitch");
endmodule : spio_port_monitor

bind spio_port spio_port_monitor #(.WAKE_CYCLES(WAKE_CYCLES))
   spio_port_monitor_i (.clk_in(clk_in), .rst_in(rst_in),
   .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
   .hwrite_in(hwrite_in), .hready_in(hready_in),
   .hreadyout_out(hreadyout_out), .hrdata_out(hrdata_out),
   .pin_out(pin_out), .pin_oe_out(pin_oe_out),
   .core_reset_out(core_reset_out));

// *** spio_ext.sv ***
// External circuitry seen by the port pins.
`timescale 1ns/1ps
module spio_ext (
   // From the port
   input  wire logic [15:0] drv_in,
   input  wire logic [15:0] oe_in,
   // Outside source for released pins
   input  wire logic [15:0] src_in,
   // Wire level
   output logic      [15:0] level_out
);
   // A released pin shows the outside source, never the stale latch.
   assign level_out = (oe_in & drv_in) | (~oe_in & src_in);
endmodule : spio_ext

// *** test_sixteen_pin_io_port.sv ***
// Self-checking bench for the sixteen-pin I/O port.
`timescale 1ns/1ps
module test_sixteen_pin_io_port;
   localparam int WK = 200;
   localparam int GL = 20;
   logic        clk_in = 1'b0;
   logic        rst_in;
   logic        hsel;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic        hready;
   logic [31:0] hrdata;
   logic        hresp;
   logic [15:0] lvl_w;
   logic [15:0] pin_o;
   logic [15:0] pin_oe;
   logic [15:0] ext;
   logic        core_rst;
   int          failures;
   int          n_compared;
   int          cyc = 0;

   always #2 clk_in = ~clk_in;

   spio_port #(.WAKE_CYCLES(WK), .GLITCH_CYCLES(GL)) spio_port_i (
      .clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
      .hresp_out(hresp), .hrdata_out(hrdata), .pin_in(lvl_w),
      .pin_out(pin_o), .pin_oe_out(pin_oe), .core_reset_out(core_rst));
   spio_ext spio_ext_i (.drv_in(pin_o), .oe_in(pin_oe), .src_in(ext),
      .level_out(lvl_w));

   function automatic logic [15:0] lvl(input logic [15:0] d, l, e);
      return (d & l) | (~d & e);
   endfunction : lvl

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input string s, input logic [31:0] v, e);
      n_compared++;
      if (v !== e) begin
         failures++;
         $display("BAD %s exp %h seen %h", s, e, v);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk_in); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_in); while (hready !== 1'b1);
      r = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, string s);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(s, r, e);
   endtask : rd

   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         print_verdict();
      end
   end

   initial begin
      logic [15:0] d, l, e, v;
      logic [31:0] r;
      logic [10:0] a;
      logic        b;
      int          i;
      int          n;
      int          p;
      failures = 0;
      n_compared = 0;
      rst_in = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      ext = 16'h0;
      r = $urandom(99);
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      rd(spio_pkg::OFF_DIR, 32'h0, "dir");
      chk("oe", pin_oe, 16'h0);
      $display("test reset done");
      for (i = 0; i < 8; i++) begin
         d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0 : 16'($urandom);
         l = 16'($urandom);
         e = 16'($urandom);
         v = lvl(d, l, e);
         ext <= e;
         wr(spio_pkg::OFF_KICK, 32'h0);
         wr(spio_pkg::OFF_DIR, {16'h0, d});
         wr(spio_pkg::OFF_DRIVE, {16'h0, l});
         repeat (4) @(posedge clk_in);
         chk("oe", pin_oe, d);
         chk("pins", pin_o, l);
         rd(spio_pkg::OFF_DRIVE, {16'h0, l}, "drive");
         rd(spio_pkg::OFF_SAMPLED, {16'h0, v}, "in");
         rd(spio_pkg::OFF_SAMP_LO, {24'h0, v[7:0]}, "in_lo");
         rd(spio_pkg::OFF_SAMP_HI, {24'h0, v[15:8]}, "in_hi");
         wr(spio_pkg::OFF_DRIVE_HI, {24'h0, e[7:0]});
         rd(spio_pkg::OFF_DRIVE, {16'h0, e[7:0], l[7:0]}, "drv_hi");
         wr(spio_pkg::OFF_DRIVE_LO, {24'h0, e[15:8]});
         rd(spio_pkg::OFF_DRIVE, {16'h0, e[7:0], e[15:8]}, "drv_lo");
         rd(spio_pkg::OFF_DRIVE_LO, {24'h0, e[15:8]}, "drv_lo_b");
         rd(spio_pkg::OFF_DRIVE_HI, {24'h0, e[7:0]}, "drv_hi_b");
      end
      $display("test random done");
      wr(spio_pkg::OFF_KICK, 32'h0);
      wr(spio_pkg::OFF_DIR, 32'h0);
      l = 16'($urandom);
      wr(spio_pkg::OFF_DRIVE, {16'h0, l});
      d = 16'h0;
      for (i = 0; i < 16; i++) begin
         b = (i == 15) ? ~l[15] : 1'($urandom);
         wr(spio_pkg::OFF_PIN_CMD, {27'h0, b, 4'(i)});
         d[i] = 1'b1;
         l[i] = b;
         rd(spio_pkg::OFF_DIR, {16'h0, d}, "dir");
         rd(spio_pkg::OFF_DRIVE, {16'h0, l}, "drive");
      end
      $display("test command done");
      a = 11'($urandom);
      v = 16'($urandom);
      wr(spio_pkg::OFF_NV_ADDR, {21'h0, a});
      wr(spio_pkg::OFF_NV_DATA, {24'h0, v[7:0]});
      wr(spio_pkg::OFF_NV_ADDR, {21'h0, a + 11'h1});
      wr(spio_pkg::OFF_NV_DATA, {24'h0, v[15:8]});
      wr(spio_pkg::OFF_NV_ADDR, {21'h0, a});
      rd(spio_pkg::OFF_NV_DATA, {24'h0, v[7:0]}, "nv_lo");
      wr(spio_pkg::OFF_NV_ADDR, {21'h0, a + 11'h1});
      rd(spio_pkg::OFF_NV_DATA, {24'h0, v[15:8]}, "nv_hi");
      rd(spio_pkg::OFF_NV_ADDR, {21'h0, a + 11'h1}, "nv_addr");
      chk("resp", hresp, 32'h0);
      chk("pins", pin_o, l);
      wr(8'h3c, 32'hffffffff);
      rd(8'h3c, 32'h0, "unmapped");
      $display("test store done");
      wr(spio_pkg::OFF_KICK, 32'h0);
      n = cyc;
      while (core_rst !== 1'b1) @(posedge clk_in);
      chk("wd_time", 32'(cyc - n > WK - 6 && cyc - n < WK + 6), 32'h1);
      repeat (3) @(posedge clk_in);
      chk("glitch", pin_oe, 16'h0);
      repeat (GL + 2) @(posedge clk_in);
      chk("restore", pin_oe, 16'hffff);
      chk("pins", pin_o, l);
      // First a sleep of two periods, then a short wait of one period.
      for (i = 0; i < 2; i++) begin
         wr(spio_pkg::OFF_CONTROL, (i == 0) ? 32'h0201 : 32'h0002);
         bus(1'b0, spio_pkg::OFF_CONTROL, 32'h0, r);
         chk("state", r[15:0], (i == 0) ? 32'h0202 : 32'h0102);
         wr(spio_pkg::OFF_DIR, 32'h0);
         n = cyc;
         p = WK * (2 - i);
         b = 1'b0;
         while (r[3:0] !== 4'h1) begin
            bus(1'b0, spio_pkg::OFF_CONTROL, 32'h0, r);
            if (pin_oe === 16'h0)
               b = 1'b1;
         end
         chk("wake", 32'(cyc - n > p - 6 && cyc - n < p + GL + 12), 1);
         chk("sl_glitch", b, 1'b1);
         rd(spio_pkg::OFF_DIR, 32'hffff, "dir");
         repeat (GL + 4) @(posedge clk_in);
      end
      $display("test sleep done");
      wr(spio_pkg::OFF_CONTROL, 32'h8);
      n = 0;
      for (i = 0; i < 3 * WK; i++) begin
         @(posedge clk_in);
         if (pin_oe !== 16'hffff || core_rst !== 1'b0)
            n++;
      end
      chk("halt_oe", n, 0);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      rd(spio_pkg::OFF_DIR, 32'h0, "dir");
      $display("test halt done");
      wr(spio_pkg::OFF_DIR, 32'h00ff);
      wr(spio_pkg::OFF_CONTROL, 32'h4);
      wr(spio_pkg::OFF_DIR, 32'hff00);
      rd(spio_pkg::OFF_DIR, 32'h00ff, "dir");
      n = cyc;
      while (pin_oe !== 16'h0) @(posedge clk_in);
      chk("end_time", 32'(cyc - n > WK - 12), 32'h1);
      repeat (GL + 4) @(posedge clk_in);
      chk("end_oe", pin_oe, 16'h00ff);
      bus(1'b0, spio_pkg::OFF_CONTROL, 32'h0, r);
      chk("ended", r[3:0], 4'h4);
      $display("test end done");
      print_verdict();
   end
endmodule : test_sixteen_pin_io_port
